/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int LC = 8;
   localparam int SC = 8;
   localparam int HC = 6;
   logic ref_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, hold_sel = 1'b0, common_input = 1'b0;
   logic coupling_a_dc = 1'b0, coupling_b_dc = 1'b0, external_reference_select = 1'b0;
   logic ext_ref_locked = 1'b1, remote_active = 1'b0, selfcheck_done = 1'b1;
   logic selfcheck_fault = 1'b1, fault_to_bus_lamps = 1'b0, go = 1'b0;
   logic [1:0] ext_ref_rate = 2'h0;
   logic [3:0] selfcheck_code = 4'h5, disp_digit, error_code;
   logic [7:0] gap1 = 8'h00, gap2 = 8'h00;
   logic [31:0] front_gate_cyc = 32'h14, delay_cyc = 32'hA, preset_gate_cyc = 32'h10;
   logic [31:0] result_count, result_events;
   ucs_pkg::ucs_keys_t keys = 6'h20;
   ucs_pkg::ucs_busaddr_t addr_switches = 6'h00, bus_cfg;
   ucs_pkg::ucs_lamps_t lamps;
   ucs_pkg::ucs_meas_t meas_kind;
   logic int_ref_out_en, ext_lock_en, ext_rate_ok, go_local, route_b_from_a;
   logic coupling_b_eff_dc, result_valid, trig_a, trig_b, busy;
   int n_fail = 0, tests_run = 0, wait_n, seen_gate, k;
   ucs_sequencer #(.LAMP_CYC(LC), .STEP_CYC(SC), .HOLD_CYC(HC)) ucs_sequencer_inst (
      .ref_clk, .clk_en, .rst_b, .keys, .hold_sel, .front_gate_cyc, .delay_cyc, .common_input,
      .coupling_a_dc, .coupling_b_dc, .external_reference_select, .ext_ref_locked,
      .ext_ref_rate, .preset_gate_cyc, .addr_switches, .remote_active, .selfcheck_done,
      .selfcheck_fault, .selfcheck_code, .fault_to_bus_lamps, .trig_a, .trig_b,
      .int_ref_out_en, .ext_lock_en, .ext_rate_ok, .bus_cfg, .go_local, .route_b_from_a,
      .coupling_b_eff_dc, .lamps, .meas_kind, .disp_digit, .result_count, .result_events,
      .result_valid, .error_code);
   ucs_src_model ucs_src_model_inst (.ref_clk, .go, .gap1, .gap2, .trig_a, .trig_b, .busy);
   initial forever #25 ref_clk = ~ref_clk;
   // ==========================================
   // Tasks
   task automatic stop_test;
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wait_res(input int lim);
      wait_n = 0;
      seen_gate = 0;
      do begin
         @(negedge ref_clk);
         wait_n++;
         if (lamps.gate === 1'b1) seen_gate = 1;
         if (wait_n > lim) begin
            chk("result_valid", 1, 0);
            stop_test();
         end
      end while (result_valid !== 1'b1);
   endtask
   task automatic fire(input logic [7:0] g1, input logic [7:0] g2);
      @(posedge ref_clk) go <= 1'b1;
      gap1 <= g1;
      gap2 <= g2;
      @(posedge ref_clk) go <= 1'b0;
      @(negedge ref_clk);
      for (int i = 0; i < 300 && busy === 1'b1; i++) @(negedge ref_clk);
      if (busy !== 1'b0) chk("src_idle", 0, busy);
   endtask
   task automatic mode(input ucs_pkg::ucs_keys_t kv);
      @(posedge ref_clk) keys <= kv;
      repeat (3) @(posedge ref_clk);
   endtask
   // ==========================================
   // Sequence; keys: fp ti tid gate shift reset
   initial begin
      repeat (2) @(negedge ref_clk);
      chk("lamp_test", 13'h1FFF, {lamps.segments_all, lamps.dp_msd,
         lamps.overflow_annunciator, lamps.hz, lamps.sec, lamps.gate});
      @(posedge ref_clk) rst_b <= 1'b1;
      for (int i = 0; i < 60 && lamps.error !== 1'b1; i++) @(negedge ref_clk);
      chk("error_lamp", 1, lamps.error);
      chk("error_code", 4'h5, error_code);
      @(posedge ref_clk) rst_b <= 1'b0;
      selfcheck_fault <= 1'b0;
      keys <= 6'h00;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2 + LC + LC / 2) @(negedge ref_clk);
      chk("zero_digit", 0, disp_digit);
      chk("trig_lamps", 2'h3, {lamps.trig_a, lamps.trig_b});
      wait_res(4 * SC);
      for (int i = 0; i < 12; i++) begin
         k = disp_digit == 4'h9 ? 4'hF : (disp_digit == 4'hF ? 0 : disp_digit + 1);
         wait_res(2 * SC);
         chk("disp_digit", k, disp_digit);
      end
      // Counting down leaves routing, reference and address inputs at zero
      for (int i = 7; i >= 0; i--) begin
         @(posedge ref_clk) {common_input, coupling_a_dc, coupling_b_dc} <= 3'(i);
         {external_reference_select, ext_ref_rate} <= 3'(i);
         addr_switches <= 6'(i * 9);
         @(negedge ref_clk) chk("coupling_b", i[2] ? i[1] : i[0], coupling_b_eff_dc);
         chk("ref_out", !i[2], int_ref_out_en);
         chk("bus_cfg", i * 9, bus_cfg);
      end
      mode(6'h20);
      fire(0, 0);
      wait_res(80);
      chk("meas_kind", ucs_pkg::UCS_MEAS_FREQ, meas_kind);
      chk("gate_length", 32'h14, result_count);
      chk("gate_lamp", 1, seen_gate);
      chk("edges", 1, result_events);
      mode(6'h22);
      fire(0, 0);
      wait_res(80);
      chk("meas_kind", ucs_pkg::UCS_MEAS_PER, meas_kind);
      @(posedge ref_clk) remote_active <= 1'b1;
      hold_sel <= 1'b1;
      mode(6'h20);
      for (int i = 0; i < 2; i++) begin
         wait_res(80);
         chk("preset_gate", 32'h10, result_count);
      end
      @(posedge ref_clk) keys <= 6'h21;
      @(negedge ref_clk) chk("go_local", 1, go_local);
      @(posedge ref_clk) keys <= 6'h20;
      remote_active <= 1'b0;
      wait_res(80);
      chk("hold_gate", HC, result_count);
      k = 0;
      repeat (6 * HC) @(negedge ref_clk) k += result_valid;
      chk("hold_repeat", 0, k);
      @(posedge ref_clk) keys <= 6'h21;
      @(posedge ref_clk) keys <= 6'h20;
      @(negedge ref_clk) chk("cleared", 0, result_count);
      wait_res(80);
      chk("hold_gate", HC, result_count);
      @(posedge ref_clk) hold_sel <= 1'b0;
      front_gate_cyc <= 32'hA;
      mode(6'h10);
      fire(0, 7);
      k = 0;
      repeat (12) @(negedge ref_clk) k += result_valid;
      chk("ti_spaced", 1, k);
      fire(0, 7);
      wait_res(100);
      chk("interval", 7, result_count);
      chk("meas_kind", ucs_pkg::UCS_MEAS_TI, meas_kind);
      mode(6'h08);
      fire(3, 15);
      repeat (12) @(posedge ref_clk);
      fire(3, 15);
      wait_res(100);
      chk("delayed", 15, result_count);
      mode(6'h1A);
      wait_res(4 * SC);
      chk("delay_shown", 32'hA, result_count);
      @(posedge ref_clk) front_gate_cyc <= 32'h28;
      mode(6'h12);
      fire(0, 5);
      fire(0, 5);
      wait_res(100);
      chk("avg_sum", 10, result_count);
      chk("avg_events", 2, result_events);
      mode(6'h06);
      wait_res(4 * SC);
      chk("gate_shown", 32'h28, result_count);
      mode(6'h20);
      fire(0, 0);
      for (int i = 0; i < 100 && lamps.gate !== 1'b1; i++) @(negedge ref_clk);
      chk("gate_open", 1, lamps.gate);
      @(posedge ref_clk) keys <= 6'h06;
      repeat (2) @(negedge ref_clk);
      chk("gate_abort", 0, lamps.gate);
      wait_res(4 * SC);
      chk("meas_kind", ucs_pkg::UCS_MEAS_GATE, meas_kind);
      stop_test();
   end
endmodule
`default_nettype wire

/* ucs_pkg.sv */
package ucs_pkg;
   // Clock and timing
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int SELFTEST_LAMP_MS = 500;
   localparam int SELFTEST_LAMP_CYC = SELFTEST_LAMP_MS * (CLK_HZ / 1000);
   localparam int DISP_STEP_MS = 250;
   localparam int DISP_STEP_CYC = DISP_STEP_MS * (CLK_HZ / 1000);
   localparam int HOLD_GATE_MS = 60;
   localparam int HOLD_GATE_CYC = HOLD_GATE_MS * (CLK_HZ / 1000);
   localparam int DELAY_MAX_MS = 30;
   localparam int DELAY_MAX_CYC = DELAY_MAX_MS * (CLK_HZ / 1000);
   localparam int GATE_MIN_MS = 60;
   localparam int GATE_MAX_S = 10;
   localparam int GATE_MAX_CYC = GATE_MAX_S * CLK_HZ;
   localparam int CNT_W = 32;
   // Display digit code that shows nothing
   localparam logic [3:0] DIGIT_BLANK = 4'hF;
   localparam logic [3:0] DIGIT_LAST = 4'h9;
   // Function selection
   typedef enum logic [4:0] {
      UCS_FN_NONE  = 5'h01,
      UCS_FN_FP    = 5'h02,
      UCS_FN_TI    = 5'h04,
      UCS_FN_TID   = 5'h08,
      UCS_FN_GATE  = 5'h10
   } ucs_fn_t;
   // Measurement kinds shown to the display logic
   typedef enum logic [2:0] {
      UCS_MEAS_FREQ = 3'h0,
      UCS_MEAS_PER  = 3'h1,
      UCS_MEAS_TI   = 3'h2,
      UCS_MEAS_TIA  = 3'h3,
      UCS_MEAS_DLY  = 3'h4,
      UCS_MEAS_GATE = 3'h5,
      UCS_MEAS_CHK  = 3'h6
   } ucs_meas_t;
   typedef enum logic [7:0] {
      UCS_ST_LAMP  = 8'h01,
      UCS_ST_ZERO  = 8'h02,
      UCS_ST_ERR   = 8'h04,
      UCS_ST_IDLE  = 8'h08,
      UCS_ST_ARM   = 8'h10,
      UCS_ST_GATE  = 8'h20,
      UCS_ST_SPACE = 8'h40,
      UCS_ST_WAIT  = 8'h80
   } ucs_state_t;
   typedef struct packed {
      logic fp;
      logic ti;
      logic tid;
      logic gate;
      logic shift;
      logic reset;
   } ucs_keys_t;
   typedef struct packed {
      logic [7:0] segments_all;
      logic       dp_msd;
      logic       overflow_annunciator;
      logic       hz;
      logic       sec;
      logic       gate;
      logic       trig_a;
      logic       trig_b;
      logic       error;
      logic       bus_flash;
   } ucs_lamps_t;
   typedef struct packed {
      logic [4:0] address;
      logic       bus_role_select;
   } ucs_busaddr_t;
endpackage

/* ucs_seq_chk_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module ucs_seq_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Stimulus
   input wire ucs_pkg::ucs_keys_t keys,
   input wire logic remote_active,
   input wire logic external_reference_select,
   input wire logic [1:0] ext_ref_rate,
   input wire ucs_pkg::ucs_busaddr_t addr_switches,
   input wire logic common_input,
   input wire logic coupling_a_dc,
   input wire logic coupling_b_dc,
   // Responses
   input wire logic int_ref_out_en,
   input wire logic ext_lock_en,
   input wire logic ext_rate_ok,
   input wire ucs_pkg::ucs_busaddr_t bus_cfg,
   input wire logic go_local,
   input wire logic route_b_from_a,
   input wire logic coupling_b_eff_dc,
   input wire ucs_pkg::ucs_lamps_t lamps,
   input wire logic [3:0] disp_digit,
   input wire logic result_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire logic nofn = !(keys.fp || keys.ti || keys.tid || keys.gate);
   wire logic [4:0] fnk = {keys.fp, keys.ti, keys.tid, keys.gate, keys.reset};
   // ==========================================
   // Assertions
   ext_ref_a: assert property (external_reference_select |-> !int_ref_out_en)
      else $error("reference jack driven while external selected");
   int_ref_a: assert property (!external_reference_select |-> int_ref_out_en && !ext_lock_en)
      else $error("internal standard not driven out");
   rate_bad_a: assert property (ext_ref_rate == 2'h3 |-> !ext_rate_ok)
      else $error("invalid reference rate accepted");
   bus_cfg_a: assert property (bus_cfg == addr_switches)
      else $error("bus address differs from switches");
   route_com_a: assert property (route_b_from_a == common_input)
      else $error("channel B routing wrong");
   coupling_b_a: assert property (coupling_b_eff_dc == (common_input ? coupling_a_dc
      : coupling_b_dc))
      else $error("channel B coupling wrong");
   go_local_a: assert property (keys.reset && remote_active |-> go_local)
      else $error("reset key did not return to local");
   digit_step_a: assert property (nofn && $past(nofn) && $changed(disp_digit)
      && disp_digit != 4'h0 |-> disp_digit == (($past(disp_digit) == 4'h9) ? 4'hF
      : $past(disp_digit) + 4'h1))
      else $error("display check skipped a step");
   abort_gate_a: assert property ($changed(fnk) && fnk != 5'h00
      && lamps.segments_all != 8'hFF |=> !lamps.gate)
      else $error("gate lamp stayed lit after function change");
   cover property (result_valid);
   cover property (go_local);
   cover property (route_b_from_a && result_valid);
endmodule
bind ucs_sequencer ucs_seq_chk ucs_seq_chk_inst (.ref_clk, .rst_b, .keys, .remote_active,
   .external_reference_select, .ext_ref_rate, .addr_switches, .common_input, .coupling_a_dc,
   .coupling_b_dc, .int_ref_out_en, .ext_lock_en, .ext_rate_ok, .bus_cfg, .go_local,
   .route_b_from_a, .coupling_b_eff_dc, .lamps, .disp_digit, .result_valid);
`default_nettype wire

/* ucs_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - External select locks timebase to 1/5/10 MHz; else internal drives reference jack.
// - Rear preset gate time used only under remote; it has no hold setting.
// - Bus address and talk-only choice come from rear address switches.
// - Power-up lights all segments and annunciators, then shows 000 with triggers lit.
// - Self-check fault shows numbered error with error lamp, or flashes bus lamps.
// - No function latched runs display check: zeros, ones, and onward, then blank.
// - Frequency/period key measures channel A frequency, or period with shift.
// - Common input takes start and stop from channel A, channel A coupling only.
// - Single interval repeats A-start to B-stop, spaced by gate-time setting.
// - Each single interval result is withheld until the gate-time spacing has elapsed.
// - Delayed interval holds off B stop after A start, ignoring inputs meanwhile.
// - Interval, delayed and shift keys together display the holdoff delay.
// - Interval key with shift selects averaging over the gate time.
// - Gate key with shift continuously displays the current gate time.
// - Reset clears and refreshes the display and returns to local control.
// - Hold makes one minimum-gate measurement, then waits for reset.
// - Gate lamp lit while the main gate is open measuring, and during the power-up lamp test.
module ucs_sequencer #(
   parameter int CNT_W = ucs_pkg::CNT_W,
   parameter int LAMP_CYC = ucs_pkg::SELFTEST_LAMP_CYC,
   parameter int STEP_CYC = ucs_pkg::DISP_STEP_CYC,
   parameter int HOLD_CYC = ucs_pkg::HOLD_GATE_CYC
) (
   // Clock, enable, reset
   input wire logic ref_clk,
   input wire logic clk_en,
   input wire logic rst_b,
   // Front panel
   input wire ucs_pkg::ucs_keys_t keys,
   input wire logic hold_sel,
   input wire logic [CNT_W-1:0] front_gate_cyc,
   input wire logic [CNT_W-1:0] delay_cyc,
   input wire logic common_input,
   input wire logic coupling_a_dc,
   input wire logic coupling_b_dc,
   // Rear panel and remote
   input wire logic external_reference_select,
   input wire logic ext_ref_locked,
   input wire logic [1:0] ext_ref_rate,
   input wire logic [CNT_W-1:0] preset_gate_cyc,
   input wire ucs_pkg::ucs_busaddr_t addr_switches,
   input wire logic remote_active,
   // Self-check result
   input wire logic selfcheck_done,
   input wire logic selfcheck_fault,
   input wire logic [3:0] selfcheck_code,
   input wire logic fault_to_bus_lamps,
   // Qualified trigger edges
   input wire logic trig_a,
   input wire logic trig_b,
   // Timebase
   output logic int_ref_out_en,
   output logic ext_lock_en,
   output logic ext_rate_ok,
   // Bus configuration
   output ucs_pkg::ucs_busaddr_t bus_cfg,
   output logic go_local,
   // Input routing
   output logic route_b_from_a,
   output logic coupling_b_eff_dc,
   // Display
   output ucs_pkg::ucs_lamps_t lamps,
   output ucs_pkg::ucs_meas_t meas_kind,
   output logic [3:0] disp_digit,
   output logic [CNT_W-1:0] result_count,
   output logic [CNT_W-1:0] result_events,
   output logic result_valid,
   output logic [3:0] error_code
);
   // ==========================================================
   // Reset synchroniser
   logic rs1_reg, rs2_reg;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rs1_reg <= 1'b0;
         rs2_reg <= 1'b0;
      end else begin
         rs1_reg <= 1'b1;
         rs2_reg <= rs1_reg;
      end
   end
   wire logic rst_n_int = rs2_reg;

   // ==========================================================
   // Timebase and bus configuration
   assign ext_lock_en = external_reference_select;
   assign int_ref_out_en = !external_reference_select;
   assign ext_rate_ok = external_reference_select && ext_ref_locked
      && (ext_ref_rate != 2'h3);
   assign bus_cfg = addr_switches;
   assign go_local = keys.reset && remote_active;
   assign route_b_from_a = common_input;
   assign coupling_b_eff_dc = common_input ? coupling_a_dc : coupling_b_dc;
   wire logic start_ev = trig_a;
   wire logic stop_ev = common_input ? trig_a : trig_b;

   // Preset gate applies only remotely and never holds
   wire logic [CNT_W-1:0] gate_cyc = remote_active ? preset_gate_cyc : front_gate_cyc;
   wire logic hold_eff = hold_sel && !remote_active;
   // Holdoff is capped at the longest delay the control offers
   wire logic [CNT_W-1:0] dly_eff = (delay_cyc > CNT_W'(ucs_pkg::DELAY_MAX_CYC))
      ? CNT_W'(ucs_pkg::DELAY_MAX_CYC) : delay_cyc;

   // ==========================================================
   // Function decode
   ucs_pkg::ucs_fn_t fn;
   always_comb begin
      if (keys.gate) fn = ucs_pkg::UCS_FN_GATE;
      else if (keys.tid) fn = ucs_pkg::UCS_FN_TID;
      else if (keys.ti) fn = ucs_pkg::UCS_FN_TI;
      else if (keys.fp) fn = ucs_pkg::UCS_FN_FP;
      else fn = ucs_pkg::UCS_FN_NONE;
   end
   ucs_pkg::ucs_meas_t kind;
   always_comb begin
      case (fn)
         ucs_pkg::UCS_FN_FP: kind = keys.shift ? ucs_pkg::UCS_MEAS_PER
            : ucs_pkg::UCS_MEAS_FREQ;
         ucs_pkg::UCS_FN_TI: kind = keys.shift ? ucs_pkg::UCS_MEAS_TIA
            : ucs_pkg::UCS_MEAS_TI;
         ucs_pkg::UCS_FN_TID: kind = (keys.ti && keys.shift) ? ucs_pkg::UCS_MEAS_DLY
            : ucs_pkg::UCS_MEAS_TI;
         ucs_pkg::UCS_FN_GATE: kind = keys.shift ? ucs_pkg::UCS_MEAS_GATE
            : ucs_pkg::UCS_MEAS_CHK;
         default: kind = ucs_pkg::UCS_MEAS_CHK;
      endcase
   end
   wire logic delayed = (fn == ucs_pkg::UCS_FN_TID) && (kind == ucs_pkg::UCS_MEAS_TI);
   wire logic is_ti = (kind == ucs_pkg::UCS_MEAS_TI) || (kind == ucs_pkg::UCS_MEAS_TIA);
   wire logic is_static = (kind == ucs_pkg::UCS_MEAS_DLY) || (kind == ucs_pkg::UCS_MEAS_GATE)
      || (fn == ucs_pkg::UCS_FN_NONE);

   // ==========================================================
   // Sequencer state
   ucs_pkg::ucs_state_t st_reg, st_next;
   ucs_pkg::ucs_meas_t kind_reg, kind_next;
   logic [CNT_W-1:0] tmr_reg, tmr_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [CNT_W-1:0] acc_reg, acc_next;
   logic [CNT_W-1:0] ev_reg, ev_next;
   logic [CNT_W-1:0] rc_reg, rc_next;
   logic [CNT_W-1:0] re_reg, re_next;
   logic rv_reg, rv_next;
   ucs_pkg::ucs_fn_t fn_reg, fn_next;
   logic in_iv_reg, in_iv_next;
   logic [3:0] dig_reg, dig_next;
   logic [3:0] err_reg, err_next;
   logic [CNT_W-1:0] gate_len;
   always_comb begin
      gate_len = hold_eff ? CNT_W'(HOLD_CYC) : gate_cyc;
      st_next = st_reg;
      kind_next = kind;
      tmr_next = tmr_reg + 1'b1;
      cnt_next = cnt_reg;
      acc_next = acc_reg;
      ev_next = ev_reg;
      rc_next = rc_reg;
      re_next = re_reg;
      rv_next = 1'b0;
      fn_next = fn;
      in_iv_next = in_iv_reg;
      dig_next = dig_reg;
      err_next = err_reg;
      case (st_reg)
         ucs_pkg::UCS_ST_LAMP: begin
            if (tmr_reg >= CNT_W'(LAMP_CYC - 1) && selfcheck_done) begin
               tmr_next = '0;
               if (selfcheck_fault) begin
                  st_next = ucs_pkg::UCS_ST_ERR;
                  err_next = selfcheck_code;
               end else begin
                  st_next = ucs_pkg::UCS_ST_ZERO;
               end
            end
         end
         ucs_pkg::UCS_ST_ZERO: begin
            if (tmr_reg >= CNT_W'(LAMP_CYC - 1)) begin
               st_next = ucs_pkg::UCS_ST_IDLE;
               tmr_next = '0;
            end
         end
         ucs_pkg::UCS_ST_ERR: tmr_next = tmr_reg + 1'b1;
         ucs_pkg::UCS_ST_IDLE: begin
            tmr_next = '0;
            dig_next = 4'h0;
            st_next = ucs_pkg::UCS_ST_ARM;
         end
         ucs_pkg::UCS_ST_ARM: begin
            cnt_next = '0;
            in_iv_next = 1'b0;
            if (is_static) begin
               if (tmr_reg >= CNT_W'(STEP_CYC - 1)) begin
                  tmr_next = '0;
                  if (fn == ucs_pkg::UCS_FN_NONE) begin
                     if (dig_reg == ucs_pkg::DIGIT_BLANK) dig_next = 4'h0;
                     else if (dig_reg == ucs_pkg::DIGIT_LAST) dig_next = ucs_pkg::DIGIT_BLANK;
                     else dig_next = dig_reg + 4'h1;
                  end
                  rc_next = (kind == ucs_pkg::UCS_MEAS_DLY) ? dly_eff : gate_cyc;
                  re_next = CNT_W'(1);
                  rv_next = 1'b1;
               end
            end else if (start_ev || !is_ti) begin
               st_next = ucs_pkg::UCS_ST_GATE;
               tmr_next = '0;
               acc_next = '0;
               ev_next = '0;
               in_iv_next = is_ti;
            end
         end
         ucs_pkg::UCS_ST_GATE: begin
            if (is_ti) begin
               if (in_iv_reg) begin
                  cnt_next = cnt_reg + 1'b1;
                  if (stop_ev && !(delayed && tmr_reg < dly_eff)) begin
                     in_iv_next = 1'b0;
                     acc_next = acc_reg + cnt_reg + 1'b1;
                     ev_next = ev_reg + 1'b1;
                     cnt_next = '0;
                  end
               end else if (start_ev && kind_reg == ucs_pkg::UCS_MEAS_TIA) begin
                  in_iv_next = 1'b1;
                  tmr_next = '0;
               end
               if ((kind_reg == ucs_pkg::UCS_MEAS_TI && in_iv_reg && !in_iv_next)
                  || (kind_reg == ucs_pkg::UCS_MEAS_TIA && tmr_reg >= gate_len)) begin
                  st_next = ucs_pkg::UCS_ST_SPACE;
                  tmr_next = '0;
               end
            end else begin
               if (start_ev) ev_next = ev_reg + 1'b1;
               if (tmr_reg >= gate_len) begin
                  st_next = ucs_pkg::UCS_ST_SPACE;
                  tmr_next = '0;
               end
            end
            // A single interval result waits for the spacing before it is shown
            if (st_next == ucs_pkg::UCS_ST_SPACE) begin
               rc_next = is_ti ? acc_next : gate_len;
               re_next = ev_next;
               rv_next = (kind_reg != ucs_pkg::UCS_MEAS_TI);
            end
         end
         ucs_pkg::UCS_ST_SPACE: begin
            // Single interval results appear only once the spacing ran out
            if (kind_reg != ucs_pkg::UCS_MEAS_TI || tmr_reg >= gate_cyc) begin
               if (kind_reg == ucs_pkg::UCS_MEAS_TI) rv_next = 1'b1;
               tmr_next = '0;
               st_next = hold_eff ? ucs_pkg::UCS_ST_WAIT : ucs_pkg::UCS_ST_ARM;
            end
         end
         ucs_pkg::UCS_ST_WAIT: begin
            tmr_next = '0;
            if (keys.reset) st_next = ucs_pkg::UCS_ST_ARM;
         end
         default: st_next = ucs_pkg::UCS_ST_LAMP;
      endcase
      // Reset key and a changed function both restart the run
      if (st_reg != ucs_pkg::UCS_ST_LAMP && st_reg != ucs_pkg::UCS_ST_ZERO
         && st_reg != ucs_pkg::UCS_ST_ERR
         && (kind != kind_reg || fn != fn_reg || keys.reset)) begin
         st_next = ucs_pkg::UCS_ST_IDLE;
         in_iv_next = 1'b0;
         rv_next = 1'b0;
         if (keys.reset) begin
            rc_next = '0;
            re_next = '0;
         end
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         st_reg <= ucs_pkg::UCS_ST_LAMP;
         kind_reg <= ucs_pkg::UCS_MEAS_CHK;
         tmr_reg <= '0;
         cnt_reg <= '0;
         acc_reg <= '0;
         ev_reg <= '0;
         rc_reg <= '0;
         re_reg <= '0;
         rv_reg <= 1'b0;
         fn_reg <= ucs_pkg::UCS_FN_NONE;
         in_iv_reg <= 1'b0;
         dig_reg <= 4'h0;
         err_reg <= 4'h0;
      end else if (clk_en) begin
         st_reg <= st_next;
         kind_reg <= kind_next;
         tmr_reg <= tmr_next;
         cnt_reg <= cnt_next;
         acc_reg <= acc_next;
         ev_reg <= ev_next;
         rc_reg <= rc_next;
         re_reg <= re_next;
         rv_reg <= rv_next;
         fn_reg <= fn_next;
         in_iv_reg <= in_iv_next;
         dig_reg <= dig_next;
         err_reg <= err_next;
      end
   end

   // ==========================================================
   // Outputs
   wire logic lamp_on = (st_reg == ucs_pkg::UCS_ST_LAMP);
   wire logic err_on = (st_reg == ucs_pkg::UCS_ST_ERR);
   always_comb begin
      lamps = '0;
      lamps.segments_all = {8{lamp_on}};
      lamps.dp_msd = lamp_on;
      lamps.overflow_annunciator = lamp_on;
      lamps.hz = lamp_on || (st_reg != ucs_pkg::UCS_ST_ZERO && !err_on
         && kind_reg == ucs_pkg::UCS_MEAS_FREQ);
      lamps.sec = lamp_on || (!err_on && st_reg != ucs_pkg::UCS_ST_ZERO
         && kind_reg != ucs_pkg::UCS_MEAS_FREQ && kind_reg != ucs_pkg::UCS_MEAS_CHK);
      lamps.gate = lamp_on || (st_reg == ucs_pkg::UCS_ST_GATE);
      lamps.trig_a = (st_reg == ucs_pkg::UCS_ST_ZERO);
      lamps.trig_b = (st_reg == ucs_pkg::UCS_ST_ZERO);
      lamps.error = err_on && !fault_to_bus_lamps;
      lamps.bus_flash = err_on && fault_to_bus_lamps && tmr_reg[22];
   end
   assign meas_kind = kind_reg;
   assign disp_digit = (st_reg == ucs_pkg::UCS_ST_ZERO) ? 4'h0 : dig_reg;
   assign result_count = rc_reg;
   assign result_events = re_reg;
   assign result_valid = rv_reg;
   assign error_code = err_reg;
endmodule
`default_nettype wire

/* ucs_src_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ucs_src_model (
   // Clock
   input wire logic ref_clk,
   // Request: start edge, then stops after gap1 (0 = none) and gap2 cycles
   input wire logic go,
   input wire logic [7:0] gap1,
   input wire logic [7:0] gap2,
   // Qualified edges
   output logic trig_a,
   output logic trig_b,
   output logic busy
);
   int n = -1;
   assign busy = (n >= 0);
   always @(posedge ref_clk) begin
      trig_a <= 1'b0;
      trig_b <= 1'b0;
      if (n < 0) begin
         if (go) begin
            trig_a <= 1'b1;
            n <= 0;
         end
      end else begin
         n <= n + 1;
         if (n + 1 == gap1 || n + 1 == gap2) trig_b <= 1'b1;
         // Four idle cycles keep 200 ns between a stop and the next start
         if (n + 1 >= gap2 + 4) n <= -1;
      end
   end
endmodule
`default_nettype wire
